//--- verilog/ueq_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts of the link register bank
// Assumes: 8-bit registers on a byte-addressed internal port, 100 MHz clock
// Notes:   Definitions only
`ifndef UEQ_DEFINES_SVH
`define UEQ_DEFINES_SVH

`define UEQ_ADDR_DS_GAIN        8'h20
`define UEQ_ADDR_US_GAIN        8'h21
`define UEQ_ADDR_LINK_CTRL      8'h22
`define UEQ_RESET_VALUE         8'h00

`define UEQ_FLD_GAIN2_HI        7
`define UEQ_FLD_GAIN2_LO        4
`define UEQ_FLD_GAIN1_HI        3
`define UEQ_FLD_GAIN1_LO        0
`define UEQ_FLD_COMPLIANCE_ACTIVE_FLAG       7
`define UEQ_FLD_LFPS_GAIN       6
`define UEQ_FLD_DEBOUNCE        5
`define UEQ_FLD_RXDET_OFF       4
`define UEQ_FLD_PERIOD_HI       3
`define UEQ_FLD_PERIOD_LO       2
`define UEQ_FLD_COMPL_HI        1
`define UEQ_FLD_COMPL_LO        0

// Times in their own units, cycle counts derived at 100 MHz (10 ns)
`define UEQ_CLK_PERIOD_NS       10
`define UEQ_DEBOUNCE_US         200
`define UEQ_DEBOUNCE_CYCLES     ((`UEQ_DEBOUNCE_US * 1000) / `UEQ_CLK_PERIOD_NS)
`define UEQ_PERIOD_8_MS         8
`define UEQ_PERIOD_12_MS        12
`define UEQ_PERIOD_8_CYCLES     ((`UEQ_PERIOD_8_MS * 1000000) / `UEQ_CLK_PERIOD_NS)
`define UEQ_PERIOD_12_CYCLES    ((`UEQ_PERIOD_12_MS * 1000000) / `UEQ_CLK_PERIOD_NS)

`endif

//--- verilog/ueq_pkg.sv
// Purpose: Types shared by the link register bank
// Assumes: Constants live in ueq_defines.svh
// Notes:   Types only
package ueq_pkg;

   typedef enum logic [1:0] {
      UEQ_CM_AUTO     = 2'b00,
      UEQ_CM_DFP_DIR  = 2'b01,
      UEQ_CM_UFP_DIR  = 2'b10,
      UEQ_CM_DISABLED = 2'b11
   } ueq_compl_type;

   typedef enum logic [1:0] {
      UEQ_LP_ACTIVE   = 2'b00,
      UEQ_LP_SLEEP    = 2'b01,
      UEQ_LP_DEBOUNCE = 2'b10,
      UEQ_LP_EXIT     = 2'b11
   } ueq_lp_state_type;

endpackage

//--- verilog/ueq_interval_timer.sv
// Purpose: Free interval counter that emits a one-cycle tick every period
// Assumes: Period changes take effect when the count restarts
// Notes:   Held idle while run is low
`timescale 1ns/1ps
module ueq_interval_timer #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] period,
   output logic                  tick
);
   logic [WIDTH-1:0] count_r;

   // Count down, reload on expiry; a stopped timer restarts a full period later
   always_ff @(posedge clk) begin
      if (sys_rst || !run) begin
         count_r <= period;
         tick    <= 1'b0;
      end else if (count_r <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
         count_r <= period;
         tick    <= 1'b1;
      end else begin
         count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
         tick    <= 1'b0;
      end
   end
endmodule

//--- verilog/ueq_link_regs.sv
// Purpose: Gain select and link power / compliance register bank for the redriver link side
// Assumes: Internal byte register port from the serial management slave, same clock domain
// Notes:   Strap pins and line-condition inputs are asynchronous and synchronised here
//
// Notes on behaviour
// - Bits 7:4 of the downstream gain register are the second downstream receiver gain code.
// - Without override each gain field mirrors its sampled straps; with override it keeps software's value.
// - Bits 3:0 of the downstream gain register are the first downstream receiver gain code.
// - Bits 3:0 of the upstream gain register pick 0 to 11 dB for the upstream receiver, mirroring its straps without override.
// - Bit 7 of the link control register reads one only while compliance mode is active.
// - With lfps gain apply clear the receiver gain is forced to zero during LFPS, else the selected codes apply.
// - With debounce set, LFPS must persist 200 us before leaving U2 or U3; clear means no debounce.
// - Rx.Detect runs in U2 or U3 unless the low-power detect-off bit is one.
// - The detect period field picks 8 ms for 00 and 12 ms for 01, codes 10 and 11 reserved, reset 00.
// - The compliance field selects state-machine choice, forced downstream, forced upstream or disabled.
// - All three registers reset to zero and the upper upstream bits read as zero.
`timescale 1ns/1ps
`include "ueq_defines.svh"
module ueq_link_regs #(
   parameter int DEBOUNCE_CYCLES = `UEQ_DEBOUNCE_CYCLES,
   parameter int PERIOD_8_CYCLES = `UEQ_PERIOD_8_CYCLES,
   parameter int PERIOD_12_CYCLES = `UEQ_PERIOD_12_CYCLES
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // Register port
   input  wire logic [7:0]            reg_addr,
   input  wire logic                  reg_wr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   // General control override bit, held elsewhere
   input  wire logic                  gain_software_override,
   // Strap levels, asynchronous
   input  wire logic [1:0]            downstream_gain_straps,
   input  wire logic [1:0]            upstream_gain_straps,
   // Line conditions from the analog side, asynchronous
   input  wire logic                  lfps_present,
   input  wire logic                  in_low_power,
   input  wire logic                  fsm_compliance_req,
   // Outputs to the analog side
   output logic      [3:0]            first_downstream_gain,
   output logic      [3:0]            second_downstream_gain,
   output logic      [3:0]            upstream_gain,
   output logic                       lowpower_exit,
   output logic                       rx_detect_pulse,
   output ueq_pkg::ueq_compl_type     compliance_mode,
   output logic                       compliance_active_flag
);
   import ueq_pkg::*;

   logic [3:0]       second_downstream_gain_code_r;
   logic [3:0]       first_downstream_gain_code_r;
   logic [3:0]       upstream_gain_code_r;
   logic             lfps_gain_apply_r;
   logic             lowpower_exit_debounce_en_r;
   logic             lowpower_rx_detect_off_r;
   logic [1:0]       downstream_detect_period_r;
   ueq_compl_type    compliance_direction_ctrl_r;
   logic [1:0]       ds_strap_s1_r;
   logic [1:0]       ds_strap_s2_r;
   logic [1:0]       us_strap_s1_r;
   logic [1:0]       us_strap_s2_r;
   logic [2:0]       line_s1_r;
   logic [2:0]       line_s2_r;
   ueq_lp_state_type lp_state_r;
   logic [31:0]      deb_count_r;
   logic [31:0]      detect_period;
   logic             detect_run;
   logic             detect_tick;
   logic             wr_ds;
   logic             wr_us;
   logic             wr_link;

   // Map a two-level strap pair onto a 4-bit gain code (straps set the two upper code bits)
   function automatic logic [3:0] strap_to_gain(input logic [1:0] straps);
      strap_to_gain = {straps, 2'b00};
   endfunction

   // Clamp the upstream code so it never exceeds the 11 dB setting
   function automatic logic [3:0] clamp_upstream(input logic [3:0] code);
      clamp_upstream = (code > 4'hb) ? 4'hb : code;
   endfunction

   // Write decode
   assign wr_ds   = reg_wr && (reg_addr == `UEQ_ADDR_DS_GAIN);
   assign wr_us   = reg_wr && (reg_addr == `UEQ_ADDR_US_GAIN);
   assign wr_link = reg_wr && (reg_addr == `UEQ_ADDR_LINK_CTRL);

   // Two-stage synchronisers for straps and line conditions
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ds_strap_s1_r <= 2'h0;
         ds_strap_s2_r <= 2'h0;
         us_strap_s1_r <= 2'h0;
         us_strap_s2_r <= 2'h0;
         line_s1_r     <= 3'h0;
         line_s2_r     <= 3'h0;
      end else begin
         ds_strap_s1_r <= downstream_gain_straps;
         ds_strap_s2_r <= ds_strap_s1_r;
         us_strap_s1_r <= upstream_gain_straps;
         us_strap_s2_r <= us_strap_s1_r;
         line_s1_r     <= {fsm_compliance_req, in_low_power, lfps_present};
         line_s2_r     <= line_s1_r;
      end
   end

   // Downstream gain fields: straps track unless override, then software owns them
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         second_downstream_gain_code_r <= 4'h0;
         first_downstream_gain_code_r  <= 4'h0;
      end else if (!gain_software_override) begin
         second_downstream_gain_code_r <= strap_to_gain(ds_strap_s2_r);
         first_downstream_gain_code_r  <= strap_to_gain(ds_strap_s2_r);
      end else if (wr_ds) begin
         second_downstream_gain_code_r <=
            reg_wdata[`UEQ_FLD_GAIN2_HI:`UEQ_FLD_GAIN2_LO];
         first_downstream_gain_code_r  <=
            reg_wdata[`UEQ_FLD_GAIN1_HI:`UEQ_FLD_GAIN1_LO];
      end
   end

   // Upstream gain field; the upper nibble has no storage at all
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         upstream_gain_code_r <= 4'h0;
      end else if (!gain_software_override) begin
         upstream_gain_code_r <= strap_to_gain(us_strap_s2_r);
      end else if (wr_us) begin
         upstream_gain_code_r <= reg_wdata[3:0];
      end
   end

   // Link control bits; bit 7 is status only so writes to it fall away
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lfps_gain_apply_r           <= 1'b0;
         lowpower_exit_debounce_en_r <= 1'b0;
         lowpower_rx_detect_off_r    <= 1'b0;
         downstream_detect_period_r  <= 2'h0;
         compliance_direction_ctrl_r <= UEQ_CM_AUTO;
      end else if (wr_link) begin
         lfps_gain_apply_r           <= reg_wdata[`UEQ_FLD_LFPS_GAIN];
         lowpower_exit_debounce_en_r <= reg_wdata[`UEQ_FLD_DEBOUNCE];
         lowpower_rx_detect_off_r    <= reg_wdata[`UEQ_FLD_RXDET_OFF];
         downstream_detect_period_r  <= reg_wdata[`UEQ_FLD_PERIOD_HI:`UEQ_FLD_PERIOD_LO];
         compliance_direction_ctrl_r <=
            ueq_compl_type'(reg_wdata[`UEQ_FLD_COMPL_HI:`UEQ_FLD_COMPL_LO]);
      end
   end

   // Read mux, registered; unmapped addresses read zero
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `UEQ_ADDR_DS_GAIN:
               reg_rdata <= {second_downstream_gain_code_r, first_downstream_gain_code_r};
            `UEQ_ADDR_US_GAIN:
               reg_rdata <= {4'h0, upstream_gain_code_r};
            `UEQ_ADDR_LINK_CTRL:
               reg_rdata <= {compliance_active_flag, lfps_gain_apply_r,
                             lowpower_exit_debounce_en_r, lowpower_rx_detect_off_r,
                             downstream_detect_period_r, compliance_direction_ctrl_r};
            default:
               reg_rdata <= 8'h00;
         endcase
      end
   end

   // Applied gains: zero during LFPS unless software asks for the selected codes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         first_downstream_gain  <= 4'h0;
         second_downstream_gain <= 4'h0;
         upstream_gain          <= 4'h0;
      end else if (line_s2_r[0] && !lfps_gain_apply_r) begin
         first_downstream_gain  <= 4'h0;
         second_downstream_gain <= 4'h0;
         upstream_gain          <= 4'h0;
      end else begin
         first_downstream_gain  <= first_downstream_gain_code_r;
         second_downstream_gain <= second_downstream_gain_code_r;
         upstream_gain          <= clamp_upstream(upstream_gain_code_r);
      end
   end

   // Low-power exit sequencing with optional LFPS debounce
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lp_state_r    <= UEQ_LP_ACTIVE;
         deb_count_r   <= 32'h0;
         lowpower_exit <= 1'b0;
      end else begin
         lowpower_exit <= 1'b0;
         case (lp_state_r)
            UEQ_LP_ACTIVE: begin
               if (line_s2_r[1]) begin
                  lp_state_r <= UEQ_LP_SLEEP;
               end
            end
            UEQ_LP_SLEEP: begin
               deb_count_r <= 32'h0;
               if (!line_s2_r[1]) begin
                  lp_state_r <= UEQ_LP_ACTIVE;
               end else if (line_s2_r[0]) begin
                  lp_state_r <= lowpower_exit_debounce_en_r ? UEQ_LP_DEBOUNCE
                                                            : UEQ_LP_EXIT;
               end
            end
            UEQ_LP_DEBOUNCE: begin
               // A dropout restarts the wait, so glitches cannot wake the link
               if (!line_s2_r[0]) begin
                  lp_state_r <= UEQ_LP_SLEEP;
               end else if (deb_count_r >= 32'(DEBOUNCE_CYCLES - 1)) begin
                  lp_state_r <= UEQ_LP_EXIT;
               end else begin
                  deb_count_r <= deb_count_r + 32'h1;
               end
            end
            UEQ_LP_EXIT: begin
               lowpower_exit <= 1'b1;
               lp_state_r    <= UEQ_LP_ACTIVE;
            end
            default: begin
               lp_state_r <= UEQ_LP_ACTIVE;
            end
         endcase
      end
   end

   // Detect period: reserved codes fall back to the 12 ms setting
   assign detect_period = (downstream_detect_period_r == 2'b00) ? 32'(PERIOD_8_CYCLES)
                                                                : 32'(PERIOD_12_CYCLES);
   assign detect_run    = (lp_state_r != UEQ_LP_ACTIVE) && !lowpower_rx_detect_off_r;

   ueq_interval_timer #(
      .WIDTH (32)
   ) u_detect_timer (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (detect_run),
      .period  (detect_period),
      .tick    (detect_tick)
   );

   // Rx.Detect strobe and compliance resolution
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rx_detect_pulse        <= 1'b0;
         compliance_mode        <= UEQ_CM_AUTO;
         compliance_active_flag <= 1'b0;
      end else begin
         rx_detect_pulse <= detect_tick && detect_run;
         compliance_mode <= compliance_direction_ctrl_r;
         case (compliance_direction_ctrl_r)
            UEQ_CM_AUTO:     compliance_active_flag <= line_s2_r[2];
            UEQ_CM_DFP_DIR:  compliance_active_flag <= 1'b1;
            UEQ_CM_UFP_DIR:  compliance_active_flag <= 1'b1;
            UEQ_CM_DISABLED: compliance_active_flag <= 1'b0;
            default:         compliance_active_flag <= 1'b0;
         endcase
      end
   end
endmodule

//--- verification/ueq_host_model.sv
// Purpose: Serial management controller model driving the internal byte register port
// Assumes: One access at a time, strobes raised and dropped on rising clock edges
// Notes:   Write data is inverted once released so stale values are never seen
`timescale 1ns/1ps
module ueq_host_model (
   input  wire logic       clk,
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   output logic            gain_software_override
);
   // Quiet port at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      gain_software_override = 1'b0;
   end

   // One-cycle write strobe, data scrambled once released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask

   // One-cycle read strobe, data taken once the registered answer lands
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Override driven to the requested level on a rising clock edge
   task automatic set_ovr(input logic v);
      @(posedge clk);
      gain_software_override <= v;
   endtask
endmodule

//--- verification/ueq_link_regs_sva.sv
// Purpose: Port-level checks of the link register bank
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
module ueq_link_regs_sva
   import ueq_pkg::*;
(
   input wire logic          clk,
   input wire logic          sys_rst,
   input wire logic [7:0]    reg_addr,
   input wire logic          reg_wr,
   input wire logic [7:0]    reg_wdata,
   input wire logic          reg_rd,
   input wire logic [7:0]    reg_rdata,
   input wire logic          gain_software_override,
   input wire logic          lfps_present,
   input wire logic [3:0]    first_downstream_gain,
   input wire logic [3:0]    second_downstream_gain,
   input wire logic [3:0]    upstream_gain,
   input wire logic          lowpower_exit,
   input wire logic          rx_detect_pulse,
   input wire ueq_compl_type compliance_mode,
   input wire logic          compliance_active_flag
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Gain write with override up and the line quiet long enough to pass sync
   sequence s_ds_wr;
      reg_wr && reg_addr == 8'h20 && gain_software_override && !lfps_present
         && !$past(lfps_present) && !$past(lfps_present, 2);
   endsequence
   sequence s_hold;
      gain_software_override && !lfps_present;
   endsequence

   property p_reset_clear;
      disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00 && upstream_gain == 4'h0
         && first_downstream_gain == 4'h0 && !compliance_active_flag;
   endproperty
   property p_ds_gain;
      s_ds_wr ##1 s_hold |=> second_downstream_gain == $past(reg_wdata[7:4], 2)
         && first_downstream_gain == $past(reg_wdata[3:0], 2);
   endproperty
   property p_us_clamp;
      upstream_gain <= 4'hb;
   endproperty
   property p_us_reserved;
      reg_rd && reg_addr == 8'h21 |=> reg_rdata[7:4] == 4'h0;
   endproperty
   property p_unmapped;
      reg_rd && (reg_addr < 8'h20 || reg_addr > 8'h22) |=> reg_rdata == 8'h00;
   endproperty
   property p_cm_off;
      (compliance_mode == UEQ_CM_DISABLED) [*2] |-> !compliance_active_flag;
   endproperty
   property p_cm_forced;
      (compliance_mode == UEQ_CM_DFP_DIR || compliance_mode == UEQ_CM_UFP_DIR) [*2]
         |-> compliance_active_flag;
   endproperty
   property p_exit_pulse;
      $rose(lowpower_exit) |=> !lowpower_exit;
   endproperty
   property p_detect_gap;
      rx_detect_pulse |=> !rx_detect_pulse [*8];
   endproperty

   a_reset_clear: assert property (p_reset_clear) else $error("bank not cleared by reset");
   a_ds_gain: assert property (p_ds_gain) else $error("downstream gains differ from write");
   a_us_clamp: assert property (p_us_clamp) else $error("upstream gain above 11 dB code");
   a_us_reserved: assert property (p_us_reserved) else $error("upstream high bits not zero");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_cm_off: assert property (p_cm_off) else $error("compliance flag while disabled");
   a_cm_forced: assert property (p_cm_forced) else $error("compliance flag low while forced");
   a_exit_pulse: assert property (p_exit_pulse) else $error("exit pulse too long");
   a_detect_gap: assert property (p_detect_gap) else $error("detect pulses too close");
endmodule

bind ueq_link_regs ueq_link_regs_sva u_sva (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .gain_software_override(gain_software_override), .lfps_present(lfps_present),
   .first_downstream_gain(first_downstream_gain), .second_downstream_gain(second_downstream_gain),
   .upstream_gain(upstream_gain), .lowpower_exit(lowpower_exit),
   .rx_detect_pulse(rx_detect_pulse), .compliance_mode(compliance_mode),
   .compliance_active_flag(compliance_active_flag));

//--- verification/test_usb_eq_link_power_regs.sv
// Purpose: Directed register and line-condition tests of the link register bank
// Assumes: Short counts set by parameter so the run stays brief
// Notes:   Register access goes through the controller model tasks
`timescale 1ns/1ps
module test_usb_eq_link_power_regs;
   import ueq_pkg::*;
   localparam int DB = 8;
   localparam int P8 = 16;
   localparam int P12 = 24;
   logic          clk = 1'b0;
   logic          sys_rst = 1'b1;
   logic [7:0]    reg_addr, reg_wdata, reg_rdata, rd;
   logic          reg_wr, reg_rd, ovr, lp_exit, det, cm_flag;
   logic [1:0]    ds_st = 2'h0, us_st = 2'h0;
   logic          lfps = 1'b0, lp = 1'b0, fsm = 1'b0;
   logic [3:0]    g1, g2, gu;
   ueq_compl_type cm;
   int            error_cnt = 0, n_tests = 0, cyc = 0, n;

   ueq_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gain_software_override(ovr));
   ueq_link_regs #(.DEBOUNCE_CYCLES(DB), .PERIOD_8_CYCLES(P8), .PERIOD_12_CYCLES(P12)) dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gain_software_override(ovr),
      .downstream_gain_straps(ds_st), .upstream_gain_straps(us_st), .lfps_present(lfps),
      .in_low_power(lp), .fsm_compliance_req(fsm), .first_downstream_gain(g1),
      .second_downstream_gain(g2), .upstream_gain(gu), .lowpower_exit(lp_exit),
      .rx_detect_pulse(det), .compliance_mode(cm), .compliance_active_flag(cm_flag));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Bounded waits, a hang shows up as an out-of-range count
   task automatic cnt_det(output int c);
      c = 0;
      while (det !== 1'b1 && c < 100) begin
         @(posedge clk);
         #1 c++;
      end
   endtask
   task automatic cnt_exit(output int c);
      c = 0;
      while (lp_exit !== 1'b1 && c < 100) begin
         @(posedge clk);
         #1 c++;
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Cycle ceiling well above the directed sequence length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end

   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 8'h20; a <= 8'h23; a++) begin
         u_host.rd(a[7:0], rd);
         chk("reset value", 8'h00, rd);
      end
      $display("test reset done");
      ds_st <= 2'b10;
      us_st <= 2'b11;
      u_host.wr(8'h20, 8'h12);
      repeat (6) @(posedge clk);
      u_host.rd(8'h20, rd);
      chk("ds mirror", 8'h88, rd);
      u_host.rd(8'h21, rd);
      chk("us mirror", 8'h0c, rd);
      chk("us gain", 8'h0b, {4'h0, gu});
      chk("gain1 strap", 8'h08, {4'h0, g1});
      chk("gain2 strap", 8'h08, {4'h0, g2});
      $display("test straps done");
      u_host.set_ovr(1'b1);
      u_host.wr(8'h20, 8'h5a);
      u_host.wr(8'h21, 8'hf7);
      ds_st <= 2'b01;
      u_host.rd(8'h20, rd);
      chk("ds override", 8'h5a, rd);
      u_host.rd(8'h21, rd);
      chk("us reserved", 8'h07, rd);
      chk("gain2 sw", 8'h05, {4'h0, g2});
      chk("gain1 sw", 8'h0a, {4'h0, g1});
      chk("us gain sw", 8'h07, {4'h0, gu});
      $display("test override done");
      fsm <= 1'b1;
      u_host.wr(8'h22, 8'hff);
      u_host.rd(8'h22, rd);
      chk("ctrl flag ro", 8'h7f, rd);
      for (int k = 0; k < 4; k++) begin
         u_host.wr(8'h22, k[7:0]);
         repeat (4) @(posedge clk);
         u_host.rd(8'h22, rd);
         chk("compliance", {k != 3, 5'h00, k[1:0]}, rd);
         chk("cm mode", k[7:0], {6'h00, cm});
      end
      $display("test compliance done");
      lfps <= 1'b1;
      repeat (5) @(posedge clk);
      chk("lfps zero", 8'h00, {g2, g1});
      chk("lfps us zero", 8'h00, {4'h0, gu});
      u_host.wr(8'h22, 8'h43);
      repeat (3) @(posedge clk);
      chk("lfps apply", 8'h5a, {g2, g1});
      chk("lfps us apply", 8'h07, {4'h0, gu});
      lfps <= 1'b0;
      $display("test lfps done");
      u_host.wr(8'h22, 8'h03);
      lp <= 1'b1;
      cnt_det(n);
      @(posedge clk);
      #1 cnt_det(n);
      chk("period 8", P8[7:0], 8'(n + 1));
      u_host.wr(8'h22, 8'h07);
      cnt_det(n);
      @(posedge clk);
      #1 cnt_det(n);
      @(posedge clk);
      #1 cnt_det(n);
      chk("period 12", P12[7:0], 8'(n + 1));
      u_host.wr(8'h22, 8'h13);
      repeat (3) @(posedge clk);
      n = 0;
      repeat (60) begin
         @(posedge clk);
         #1 n += int'(det === 1'b1);
      end
      chk("detect off", 8'h00, 8'(n));
      $display("test detect done");
      u_host.wr(8'h22, 8'h33);
      @(posedge clk);
      lfps <= 1'b1;
      cnt_exit(n);
      chk("debounce on", 8'h01, {7'h00, n >= DB && n < 100});
      lfps <= 1'b0;
      lp <= 1'b0;
      repeat (5) @(posedge clk);
      lp <= 1'b1;
      u_host.wr(8'h22, 8'h13);
      repeat (5) @(posedge clk);
      lfps <= 1'b1;
      cnt_exit(n);
      chk("debounce off", 8'h01, {7'h00, n < DB});
      $display("test low power done");
      summarize();
   end
endmodule
